// ===== design/pfp_pkg.sv
package pfp_pkg;

  // ********************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [23:0] IDX_MASK = 24'hffe384;
  localparam logic [23:0] IDX_STAT = 24'hffe385;
  localparam logic [23:0] IDX_CTL = 24'hffe388;

  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] MASK_WBITS = 8'h27;
  localparam logic [7:0] STAT_BITS = 8'ha7;
  localparam logic [7:0] CTL_WBITS = 8'h7f;
  localparam logic [7:0] FAULT_FLAGS = 8'h27;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int M_F0 = 0;
  localparam int M_CMP = 1;
  localparam int M_F1 = 2;
  localparam int M_DBG = 5;
  localparam int S_F0 = 0;
  localparam int S_F1 = 1;
  localparam int S_C0 = 2;
  localparam int S_DBG = 5;
  localparam int S_RLD = 7;
  localparam int C_F0RST = 0;
  localparam int C_F0INT = 1;
  localparam int C_C0RST = 2;
  localparam int C_C0INT = 3;
  localparam int C_C1RST = 4;
  localparam int C_C1INT = 5;
  localparam int C_DEBUG_RECOVERY_SELECT = 6;

  // Source vector order: f0, f1, c0, c1, debug
  localparam int NSRC = 5;
  localparam int SRC_F0 = 0;
  localparam int SRC_F1 = 1;
  localparam int SRC_C0 = 2;
  localparam int SRC_C1 = 3;
  localparam int SRC_DBG = 4;

  typedef enum logic {RUN, FAULT} pfp_mode_e;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [7:0] mask;
    logic locked;
    logic [7:0] stat;
    logic [7:0] ctl;
    pfp_mode_e mode;
    logic [NSRC-1:0] cause;
    logic rld_ok;
    logic [2:0] irq;
    logic exc;
    logic [31:0] rdata;
  } pfp_state_s;

  function automatic logic addr_hit(input logic [31:0] a, input logic [23:0] idx);
    return a == {6'h00, idx, 2'b00};
  endfunction

endpackage

// ===== design/pfp_fault_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Mask bits 0,1,2,5 take first write only
// - Unmasked debug entry raises a fault
// - Mask bit 2 gates fault source 1
// - Mask bit 1 gates the comparators
// - Mask bit 0 gates the fault 0 pin
// - Comparator 0 fault also raises exception
// - Masked source never sets its flag
// - Write 1 clears flag once source deasserted
// - Reload sets and holds status bit 7
// - Unmasked debug entry sets status bit 5
// - Unmasked comparator 0 sets status bit 2
// - Unmasked fault 1 sets status bit 1
// - Unmasked fault 0 sets status bit 0
// - Debug recovery waits period or software
// - Comparator 1 recovery auto or software
// - Comparator 0 recovery auto or software
// - Fault 0 recovery auto or software
// - Control bit 5 enables comparator 1 request
// - Control bit 3 enables comparator 0 request
// - Control bit 1 enables fault 0 request
// - Active fault forces all outputs off
module pfp_fault_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault0_pin,
  input wire logic fault1_pin,
  input wire logic cmp0_in,
  input wire logic cmp1_in,
  input wire logic debug_entry,
  input wire logic pwm_reload,
  input wire logic period_start,
  output logic pwm_force_off,
  output logic fault_exception,
  output logic irq_fault0,
  output logic irq_cmp0,
  output logic irq_cmp1
);

  pfp_pkg::pfp_state_s s;
  pfp_pkg::pfp_state_s n;
  logic [pfp_pkg::NSRC-1:0] raw;
  logic [pfp_pkg::NSRC-1:0] act;
  logic [pfp_pkg::NSRC-1:0] sw_sel;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [31:0] rd_val;
  logic hit_mask;
  logic hit_stat;
  logic hit_ctl;
  logic wr;
  logic sw_need;
  logic per_need;
  logic flags_clear;
  logic release_ok;

  // ********************************************************
  // Bus decode
  // ********************************************************
  assign hit_mask = pfp_pkg::addr_hit(paddr, pfp_pkg::IDX_MASK);
  assign hit_stat = pfp_pkg::addr_hit(paddr, pfp_pkg::IDX_STAT);
  assign hit_ctl = pfp_pkg::addr_hit(paddr, pfp_pkg::IDX_CTL);
  assign wr = psel && penable && pwrite;

  // Zero wait states; an unmapped address errors in the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_mask || hit_stat || hit_ctl);
  assign prdata = s.rdata;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_mask) begin
      rd_val = {24'h00_0000, s.mask};
    end else if (hit_stat) begin
      rd_val = {24'h00_0000, s.stat};
    end else if (hit_ctl) begin
      rd_val = {24'h00_0000, s.ctl};
    end
  end

  // ********************************************************
  // Source qualification
  // ********************************************************
  // Pins are synchronised; debug entry comes from the CPU clock domain
  assign raw = {debug_entry, s.sync2};
  assign act = raw & ~{s.mask[pfp_pkg::M_DBG],
                       s.mask[pfp_pkg::M_CMP],
                       s.mask[pfp_pkg::M_CMP],
                       s.mask[pfp_pkg::M_F1],
                       s.mask[pfp_pkg::M_F0]};

  // Fault 1 has no restart select and always recovers automatically
  assign sw_sel = {s.ctl[pfp_pkg::C_DEBUG_RECOVERY_SELECT],
                   s.ctl[pfp_pkg::C_C1RST],
                   s.ctl[pfp_pkg::C_C0RST],
                   1'b0,
                   s.ctl[pfp_pkg::C_F0RST]};

  // ********************************************************
  // Recovery condition
  // ********************************************************
  assign sw_need = |(s.cause & sw_sel);
  // A debug fault in automatic mode also waits for a new period
  assign per_need = s.cause[pfp_pkg::SRC_DBG] && !s.ctl[pfp_pkg::C_DEBUG_RECOVERY_SELECT];
  assign flags_clear = (s.stat & pfp_pkg::FAULT_FLAGS) == 8'h00;
  assign release_ok = !(|act) && (!per_need || period_start)
                      && (!sw_need || (flags_clear && s.rld_ok));

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    n = s;
    set_bits = 8'h00;
    clr_bits = 8'h00;

    n.sync1 = {cmp1_in, cmp0_in, fault1_pin, fault0_pin};
    n.sync2 = s.sync1;

    // One lock for the whole register: later writes fall away silently
    if (wr && hit_mask && !s.locked) begin
      n.mask = pwdata[7:0] & pfp_pkg::MASK_WBITS;
      n.locked = 1'b1;
    end

    // Flags; a set in the same cycle as its clear wins
    set_bits[pfp_pkg::S_F0] = act[pfp_pkg::SRC_F0];
    set_bits[pfp_pkg::S_F1] = act[pfp_pkg::SRC_F1];
    set_bits[pfp_pkg::S_C0] = act[pfp_pkg::SRC_C0];
    set_bits[pfp_pkg::S_DBG] = act[pfp_pkg::SRC_DBG];
    set_bits[pfp_pkg::S_RLD] = pwm_reload;
    if (wr && hit_stat) begin
      clr_bits = pwdata[7:0] & pfp_pkg::STAT_BITS;
      clr_bits[pfp_pkg::S_F0] = clr_bits[pfp_pkg::S_F0] && !raw[pfp_pkg::SRC_F0];
      clr_bits[pfp_pkg::S_F1] = clr_bits[pfp_pkg::S_F1] && !raw[pfp_pkg::SRC_F1];
      clr_bits[pfp_pkg::S_C0] = clr_bits[pfp_pkg::S_C0] && !raw[pfp_pkg::SRC_C0];
      clr_bits[pfp_pkg::S_DBG] = clr_bits[pfp_pkg::S_DBG] && !raw[pfp_pkg::SRC_DBG];
    end
    n.stat = set_bits | (s.stat & ~clr_bits);

    if (wr && hit_ctl) begin
      n.ctl = pwdata[7:0] & pfp_pkg::CTL_WBITS;
    end

    // Fault state: cause bits collect every source seen while held off
    case (s.mode)
      pfp_pkg::RUN: begin
        n.rld_ok = 1'b0;
        if (|act) begin
          n.mode = pfp_pkg::FAULT;
          n.cause = act;
        end
      end
      pfp_pkg::FAULT: begin
        n.cause = s.cause | act;
        if (pwm_reload) begin
          n.rld_ok = 1'b1;
        end
        if (release_ok) begin
          n.mode = pfp_pkg::RUN;
          n.cause = '0;
          n.rld_ok = 1'b0;
        end
      end
      default: begin
        n.mode = pfp_pkg::RUN;
      end
    endcase

    // Requests follow the pin, not the mask
    n.irq[2] = s.ctl[pfp_pkg::C_C1INT] && raw[pfp_pkg::SRC_C1];
    n.irq[1] = s.ctl[pfp_pkg::C_C0INT] && raw[pfp_pkg::SRC_C0];
    n.irq[0] = s.ctl[pfp_pkg::C_F0INT] && raw[pfp_pkg::SRC_F0];
    n.exc = act[pfp_pkg::SRC_C0];

    // Read data is caught in the setup phase for a flop-driven prdata
    if (psel && !penable) begin
      n.rdata = rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{sync1: 4'h0, sync2: 4'h0, mask: pfp_pkg::MASK_RESET,
             locked: 1'b0, stat: pfp_pkg::STAT_RESET, ctl: pfp_pkg::CTL_RESET,
             mode: pfp_pkg::RUN, cause: 5'h00, rld_ok: 1'b0, irq: 3'h0,
             exc: 1'b0, rdata: 32'h0000_0000};
    end else begin
      s <= n;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign pwm_force_off = s.mode == pfp_pkg::FAULT;
  assign fault_exception = s.exc;
  assign irq_cmp1 = s.irq[2];
  assign irq_cmp0 = s.irq[1];
  assign irq_fault0 = s.irq[0];

  // ********************************************************
  // Checks
  // ********************************************************
  mask_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.locked && wr && hit_mask |=> $stable(s.mask))
    else $error("mask changed after first write");

  dbg_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    debug_entry && !s.mask[5] |=> pwm_force_off && s.stat[5])
    else $error("debug entry did not fault");

  dbg_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mode == pfp_pkg::RUN && s.mask == 8'h20 && s.sync2 == 4'h0 |=> !pwm_force_off)
    else $error("masked debug entry faulted");

  f1_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.sync2[1] && !s.mask[2] |=> pwm_force_off && s.stat[1])
    else $error("fault 1 not raised");

  cmp_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.sync2[2] && !s.mask[1] |=> pwm_force_off && fault_exception && s.stat[2])
    else $error("comparator 0 not raised");

  cmp_exc_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_exception |-> pwm_force_off && $past(s.sync2[2]))
    else $error("exception without comparator fault");

  f0_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.sync2[0] && !s.mask[0] |=> pwm_force_off && s.stat[0])
    else $error("fault 0 not raised");

  masked_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mask[0] && !s.stat[0] |=> !s.stat[0])
    else $error("masked fault 0 set its flag");

  clr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_stat && pwdata[0] && s.sync2[0] && s.stat[0] |=> s.stat[0])
    else $error("flag cleared while source asserted");

  clr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_stat && !pwdata[7] && s.stat[7] |=> s.stat[7])
    else $error("writing zero cleared reload flag");

  reload_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_reload |=> s.stat[7] [*1])
    else $error("reload flag not set");

  dbg_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force_off && s.cause[4] && !s.ctl[6] && !period_start |=> pwm_force_off)
    else $error("debug fault released without new period");

  sw_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force_off && (s.cause & sw_sel) != 5'h00 && !s.rld_ok |=> pwm_force_off)
    else $error("software recovery released without reload");

  auto_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force_off && s.cause == 5'h01 && !s.ctl[0] && act == 5'h00 |=> !pwm_force_off)
    else $error("automatic fault 0 recovery stalled");

  irq_c1_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.ctl[5] |=> !irq_cmp1)
    else $error("comparator 1 request while disabled");

  irq_c0_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.ctl[3] && s.sync2[2] |=> irq_cmp0)
    else $error("comparator 0 request missing");

  irq_f0_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_fault0 |-> $past(s.ctl[1]) && $past(s.sync2[0]))
    else $error("fault 0 request without cause");

  hold_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    act != 5'h00 |=> pwm_force_off)
    else $error("outputs not forced off during fault");

  // ********************************************************
  // Mask, flag, request, exception and recovery checks
  // ********************************************************
  mask_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.locked && wr && hit_mask |=> s.locked && s.mask == ($past(pwdata[7:0]) & pfp_pkg::MASK_WBITS))
    else $error("first mask write not taken");

  mask_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mask & ~pfp_pkg::MASK_WBITS) == 8'h00)
    else $error("reserved mask bit set");

  dbg_masked_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mask[pfp_pkg::M_DBG] && !s.stat[pfp_pkg::S_DBG] |=> !s.stat[pfp_pkg::S_DBG])
    else $error("masked debug entry set its flag");

  f1_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mask[pfp_pkg::M_F1] && !s.stat[pfp_pkg::S_F1] |=> !s.stat[pfp_pkg::S_F1])
    else $error("masked fault 1 set its flag");

  c0_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mask[pfp_pkg::M_CMP] && !s.stat[pfp_pkg::S_C0] |=> !s.stat[pfp_pkg::S_C0])
    else $error("masked comparator 0 set its flag");

  f0_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.stat[pfp_pkg::S_F0] && !(wr && hit_stat) |=> s.stat[pfp_pkg::S_F0])
    else $error("fault 0 flag dropped");

  f1_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.stat[pfp_pkg::S_F1] && !(wr && hit_stat) |=> s.stat[pfp_pkg::S_F1])
    else $error("fault 1 flag dropped");

  c0_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.stat[pfp_pkg::S_C0] && !(wr && hit_stat) |=> s.stat[pfp_pkg::S_C0])
    else $error("comparator 0 flag dropped");

  dbg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.stat[pfp_pkg::S_DBG] && !(wr && hit_stat) |=> s.stat[pfp_pkg::S_DBG])
    else $error("debug flag dropped");

  reload_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.stat[pfp_pkg::S_RLD] && !(wr && hit_stat) |=> s.stat[pfp_pkg::S_RLD])
    else $error("reload flag dropped");

  reload_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_stat && pwdata[pfp_pkg::S_RLD] && !pwm_reload |=> !s.stat[pfp_pkg::S_RLD])
    else $error("reload flag not cleared");

  f0_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_stat && pwdata[pfp_pkg::S_F0] && !raw[pfp_pkg::SRC_F0] |=> !s.stat[pfp_pkg::S_F0])
    else $error("fault 0 flag not cleared");

  exc_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.mask[pfp_pkg::M_CMP] |=> !fault_exception)
    else $error("exception from masked comparator");

  c1_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.ctl[pfp_pkg::C_C1INT] && s.sync2[3] |=> irq_cmp1)
    else $error("comparator 1 request missing");

  c0_irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.ctl[pfp_pkg::C_C0INT] |=> !irq_cmp0)
    else $error("comparator 0 request while disabled");

  f0_irq_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.ctl[pfp_pkg::C_F0INT] && s.sync2[0] |=> irq_fault0)
    else $error("fault 0 request missing");

  run_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pwm_force_off |-> s.cause == 5'h00)
    else $error("cause left over in run state");

  src_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force_off && act != 5'h00 |=> pwm_force_off)
    else $error("released while a source is active");

  c1_sw_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force_off && s.cause[pfp_pkg::SRC_C1] && s.ctl[pfp_pkg::C_C1RST] && !s.rld_ok
    |=> pwm_force_off)
    else $error("comparator 1 released without reload");

  dbg_sw_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force_off && s.cause[pfp_pkg::SRC_DBG] && s.ctl[pfp_pkg::C_DEBUG_RECOVERY_SELECT] && !flags_clear
    |=> pwm_force_off)
    else $error("debug fault released with flags set");

  reload_seen_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_force_off && pwm_reload |=> s.rld_ok || !pwm_force_off)
    else $error("reload during fault not recorded");

endmodule

`default_nettype wire

// ===== testbench/pfp_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Fault sources and PWM timer events
// ****
module pfp_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] req,
  output logic [4:0] pins,
  output logic pwm_reload,
  output logic period_start
);
  logic [2:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      pins <= 5'h00;
    end else begin
      cnt <= cnt + 3'h1;
      pins <= req;
    end
  end
  // Short period keeps recovery waits brief
  assign pwm_reload = (cnt == 3'h7);
  assign period_start = (cnt == 3'h7);
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Fault unit bench
// ****
module tb_top;
  localparam logic [31:0] A_MASK = {6'h00, pfp_pkg::IDX_MASK, 2'b00};
  localparam logic [31:0] A_STAT = {6'h00, pfp_pkg::IDX_STAT, 2'b00};
  localparam logic [31:0] A_CTL = {6'h00, pfp_pkg::IDX_CTL, 2'b00};
  localparam logic [7:0] FLAG_T [5] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h20};
  localparam logic [7:0] MASK_T [5] = '{8'h01, 8'h04, 8'h02, 8'h02, 8'h20};
  localparam logic [7:0] SW_CTL [4] = '{8'h01, 8'h04, 8'h40, 8'h10};
  localparam int SW_SRC [4] = '{0, 2, 4, 3};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] req = 5'h00;
  logic [31:0] prdata, q;
  logic pready, pslverr, force_off, exc, e;
  logic [2:0] irq;
  logic [4:0] pins;
  logic rld, pst;
  logic [7:0] ctl, v;
  int s, m;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  pfp_fault_unit pfp_fault_unit_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault0_pin(pins[0]), .fault1_pin(pins[1]), .cmp0_in(pins[2]), .cmp1_in(pins[3]),
    .debug_entry(pins[4]), .pwm_reload(rld), .period_start(pst),
    .pwm_force_off(force_off), .fault_exception(exc),
    .irq_fault0(irq[0]), .irq_cmp0(irq[1]), .irq_cmp1(irq[2]));
  pfp_src_model pfp_src_model_i (
    .pclk(pclk), .presetn(presetn), .req(req), .pins(pins),
    .pwm_reload(rld), .period_start(pst));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [2:0] exp_irq(input int s, input logic [7:0] c);
    return {s == 3 && c[5], s == 2 && c[3], s == 0 && c[1]};
  endfunction

  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Each transfer starts at a fresh edge so no signal is driven twice at once
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    req <= 5'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic wait_clear();
    int n;
    n = 0;
    @(negedge pclk);
    while (force_off !== 1'b0 && n < 40) begin
      n++;
      @(negedge pclk);
    end
    // Let a reload pulse pass so the reload flag is set again
    repeat (8) @(negedge pclk);
  endtask

  initial begin
    void'($urandom(30));
    rst();
    apb(1'b0, A_MASK, 32'h0);
    chk("mask reset", 32'h0, q);
    apb(1'b0, A_CTL, 32'h0);
    chk("ctl reset", 32'h0, q);
    apb(1'b0, 32'h0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    v = 8'($urandom) & 8'h27;
    apb(1'b1, A_MASK, {24'h0, v});
    apb(1'b1, A_MASK, {24'h0, ~v & 8'h27});
    apb(1'b0, A_MASK, 32'h0);
    chk("mask lock", {24'h0, v}, q);
    apb(1'b1, A_CTL, 32'h7f);
    apb(1'b0, A_CTL, 32'h0);
    chk("ctl rw", 32'h7f, q);
    $display("test registers done");
    for (int k = 0; k < 10; k++) begin
      s = k % 5;
      m = k / 5;
      ctl = 8'($urandom) & 8'h2a;
      rst();
      apb(1'b1, A_MASK, (m == 1) ? {24'h0, MASK_T[s]} : 32'h0);
      apb(1'b1, A_CTL, {24'h0, ctl});
      req <= 5'h01 << s;
      repeat (6) @(negedge pclk);
      chk("force_off", {31'h0, m == 0}, {31'h0, force_off});
      chk("irq", {29'h0, exp_irq(s, ctl)}, {29'h0, irq});
      chk("exception", {31'h0, s == 2 && m == 0}, {31'h0, exc});
      apb(1'b0, A_STAT, 32'h0);
      chk("flag", (m == 1) ? 32'h0 : {24'h0, FLAG_T[s]}, q & 32'h27);
      apb(1'b1, A_STAT, 32'ha7);
      apb(1'b0, A_STAT, 32'h0);
      chk("flag held", (m == 1) ? 32'h0 : {24'h0, FLAG_T[s]}, q & 32'h27);
      req <= 5'h00;
      wait_clear();
      chk("auto recover", 32'h0, {31'h0, force_off});
      apb(1'b0, A_STAT, 32'h0);
      chk("reload flag", 32'h80, q & 32'h80);
      apb(1'b1, A_STAT, 32'ha7);
      apb(1'b0, A_STAT, 32'h0);
      chk("flag clear", 32'h0, q & 32'h27);
      $display("test source %0d masked %0d done", s, m);
    end
    for (int k = 0; k < 4; k++) begin
      rst();
      apb(1'b1, A_CTL, {24'h0, SW_CTL[k]});
      req <= 5'h01 << SW_SRC[k];
      repeat (6) @(posedge pclk);
      req <= 5'h00;
      repeat (20) @(posedge pclk);
      // Comparator 1 has no flag, so a reload alone lets it go
      chk("sw hold", {31'h0, k != 3}, {31'h0, force_off});
      apb(1'b1, A_STAT, 32'ha7);
      wait_clear();
      chk("sw recover", 32'h0, {31'h0, force_off});
      $display("test software restart %0d done", k);
    end
    stop_test();
  end
endmodule
`default_nettype wire
